// *** sim/dram_dev_model.sv ***
// Behavioural model of the DRAM mode register and init tracker
`timescale 1ns/1ns
`default_nettype none
module dram_dev_model #(
	parameter int NOPS = 1024
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire dram_init_pkg::dram_cmd_s cmd,
	output logic [9:0] mode_q,
	output logic mux_q,
	output logic dll_on,
	output logic init_done,
	output logic [3:0] rl,
	output logic viol_q
);
	wire ld = cmd.ctl == dram_init_pkg::CMD_MODE_LOAD;
	wire rf = cmd.ctl == dram_init_pkg::CMD_REFRESH;
	wire np = cmd.ctl == dram_init_pkg::CMD_NOP;
	wire [8:0] hi = mux_q ? cmd.addr[18:10] : {1'b0, cmd.addr[17:10]};
	logic part_b_q, loaded_q;
	logic [9:0] part_a_q;
	logic [7:0] banks_q;
	logic [15:0] nops_q;
	logic [3:0] rc;
	// Sim reset only; the real part has no reset pin
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			{mode_q, mux_q, part_b_q, loaded_q, part_a_q} <= '0;
			{banks_q, nops_q, viol_q} <= '0;
		end else begin
			part_b_q <= ld && mux_q;
			if (ld && !mux_q) begin
				mode_q <= cmd.addr[9:0];
				mux_q <= cmd.addr[5];
				loaded_q <= 1'b1;
			end
			if (ld && mux_q)
				part_a_q <= cmd.addr[9:0];
			if (part_b_q)
				mode_q <= {part_a_q[9:8], cmd.addr[9], 1'b0, part_a_q[5:3],
					cmd.addr[4:3], part_a_q[0]};
			if (rf && loaded_q)
				banks_q[cmd.bank] <= 1'b1;
			if (np && loaded_q && nops_q != '1)
				nops_q <= nops_q + 16'h1;
			if ((ld || part_b_q) && hi != '0)
				viol_q <= 1'b1;
		end
	end
	assign init_done = &banks_q && nops_q >= NOPS;
	assign dll_on = mode_q[7];
	always_comb begin
		case (mode_q[2:0])
			3'h0, 3'h1: rc = 4'h4;
			3'h2: rc = 4'h6;
			3'h3: rc = 4'h8;
			3'h4: rc = 4'h3;
			3'h5: rc = 4'h5;
			default: rc = 4'h0;
		endcase
	end
	assign rl = rc + {3'h0, mux_q};
endmodule : dram_dev_model
`default_nettype wire

// *** sim/dram_init_chk.sv ***
// Pin checker for the DRAM init controller
`timescale 1ns/1ns
`default_nettype none
module dram_init_chk #(
	parameter int POWERUP_CYCLES = 10000,
	parameter int MRSC_CYCLES = 4,
	parameter int NOP_CYCLES = 1024,
	parameter bit ALLOW_CONFIG3 = 1'b0
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire dram_init_pkg::dram_cmd_s dram_cmd
);
	wire is_ld = dram_cmd.ctl == dram_init_pkg::CMD_MODE_LOAD;
	wire is_rf = dram_cmd.ctl == dram_init_pkg::CMD_REFRESH;
	wire is_np = dram_cmd.ctl == dram_init_pkg::CMD_NOP;
	wire [2:0] cf = dram_cmd.addr[2:0];
	wire [1:0] burst = dram_cmd.addr[4:3];
	logic seen_q;
	logic [15:0] run_q, sld_q, srf_q;
	////////////////////////////////////////////////////////////////////////
	// Counters saturate so a long idle never wraps into a false fail
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			seen_q <= 1'b0;
			run_q <= '0;
			sld_q <= '1;
			srf_q <= '1;
		end else begin
			seen_q <= seen_q | is_ld;
			run_q <= is_np ? run_q + {15'h0, run_q != '1} : '0;
			sld_q <= is_ld ? 16'h1 : sld_q + {15'h0, sld_q != '1};
			srf_q <= is_rf ? 16'h1 : srf_q + {15'h0, srf_q != '1};
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////////////////
	chk_power_wait: assert property (
		is_ld && !seen_q |-> run_q >= POWERUP_CYCLES)
		else $error("mode load before power-up wait");
	chk_load_triple: assert property (
		is_ld && !seen_q |=> is_ld ##1 is_ld)
		else $error("init loads not back to back");
	chk_dummy_low: assert property (
		is_ld ##1 is_ld |-> $past(dram_cmd.addr) == '0)
		else $error("dummy load address not low");
	chk_upper_low: assert property (
		is_ld |-> dram_cmd.addr[21:10] == '0 ##1 dram_cmd.addr[21:10] == '0)
		else $error("upper address bits set in load");
	chk_settle_gap: assert property (
		!is_np && !(is_ld && sld_q == 16'h1) |-> sld_q > MRSC_CYCLES)
		else $error("command inside settle time");
	chk_bank_order: assert property (
		is_rf && dram_cmd.bank != 3'h7
		|=> is_rf && dram_cmd.bank == $past(dram_cmd.bank) + 3'h1)
		else $error("refresh bank sequence broken");
	chk_nop_tail: assert property (
		is_ld |-> srf_q > NOP_CYCLES)
		else $error("load before refresh tail ended");
	chk_cfg_legal: assert property (
		is_ld && !dram_cmd.addr[5] |-> burst != 2'h3 && cf[2:1] != 2'h3 &&
		!(burst == 2'h2 && (cf[1:0] == 2'h0 && cf != 3'h2 || cf == 3'h1)) &&
		(ALLOW_CONFIG3 || cf != 3'h3))
		else $error("illegal mode word loaded");
	cov_triple: cover property (is_ld && sld_q == 16'h1);
	cov_last_bank: cover property (is_rf && dram_cmd.bank == 3'h7);
	cov_mux_load: cover property (is_ld && dram_cmd.addr[5]);
endmodule : dram_init_chk
bind dram_init_ctrl dram_init_chk #(
	.POWERUP_CYCLES(POWERUP_CYCLES),
	.MRSC_CYCLES(MRSC_CYCLES),
	.NOP_CYCLES(NOP_CYCLES),
	.ALLOW_CONFIG3(ALLOW_CONFIG3)
) chk_i (.mclk(mclk), .rst_b(rst_b), .dram_cmd(dram_cmd));
`default_nettype wire

// *** sim/dram_init_mode_register_test.sv ***
// Self-checking bench for the DRAM init controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
	$display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module dram_init_mode_register_test;
	logic mclk, rst_b, hsel, hwrite;
	logic [31:0] haddr, hwdata, s;
	logic [1:0] htrans;
	logic [2:0] hsize;
	wire logic hready;
	wire logic [31:0] hrdata;
	wire logic hresp;
	dram_init_pkg::dram_cmd_s dram_cmd;
	logic [9:0] dev_mode;
	logic [3:0] dev_rl;
	logic dev_mux, dev_dll, dev_done, dev_viol;
	int n_tests = 0, fail_count = 0, cyc = 0;
	dram_init_ctrl #(.POWERUP_CYCLES(5), .MRSC_CYCLES(2), .NOP_CYCLES(8),
		.DLL_CYCLES(8)) uut (.mclk(mclk), .rst_b(rst_b), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hready),
		.hrdata(hrdata), .hresp(hresp), .dram_cmd(dram_cmd));
	dram_dev_model #(.NOPS(8)) dev (.mclk(mclk), .rst_b(rst_b),
		.cmd(dram_cmd), .mode_q(dev_mode), .mux_q(dev_mux), .dll_on(dev_dll),
		.init_done(dev_done), .rl(dev_rl), .viol_q(dev_viol));
	////////////////////////////////////////////////////////////////////////
	task automatic bus(input logic [31:0] a, input logic w,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= dram_init_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge mclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge mclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(a, 1'b1, d, r);
	endtask : wr
	// Poll with a bound; the caller judges the last value read
	task automatic poll(input logic [31:0] m, input logic [31:0] v);
		for (int i = 0; i < 200; i++) begin
			bus(32'h8, 1'b0, 32'h0, s);
			if ((s & m) === v)
				break;
		end
	endtask : poll
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done
	////////////////////////////////////////////////////////////////////////
	task automatic t_refuse;
		logic [9:0] bad [6] = '{10'h010, 10'h011, 10'h014, 10'h003,
			10'h006, 10'h018};
		foreach (bad[i]) begin
			wr(32'h4, {22'h0, bad[i]});
			wr(32'h0, 32'h1);
			bus(32'h8, 1'b0, 32'h0, s);
			`CHK(s, 32'h10)
			wr(32'h0, 32'h8);
		end
		`CHK(dev_mode, 10'h000)
	endtask : t_refuse
	task automatic t_init;
		wr(32'h4, 32'h38d);
		wr(32'h0, 32'h1);
		poll(32'h3, 32'h2);
		`CHK(dev_done, 1'b1)
		`CHK(dev_mode, 10'h38d)
		`CHK(dev_rl, 4'h5)
		bus(32'hc, 1'b0, 32'h0, s);
		`CHK(s, 32'h0506_0505)
		poll(32'h4, 32'h4);
		`CHK(s[2], 1'b1)
		`CHK(dev_dll, 1'b1)
		wr(32'h0, 32'h1);
		bus(32'h8, 1'b0, 32'h0, s);
		`CHK(s[4], 1'b1)
		wr(32'h0, 32'h8);
	endtask : t_init
	task automatic t_mux;
		wr(32'h4, 32'h0a4);
		wr(32'h0, 32'h2);
		poll(32'h9, 32'h8);
		`CHK(dev_mux, 1'b1)
		`CHK(dev_rl, 4'h4)
		bus(32'hc, 1'b0, 32'h0, s);
		`CHK(s, 32'h0405_0403)
		wr(32'h4, 32'h0aa);
		wr(32'h0, 32'h2);
		poll(32'h1, 32'h0);
		`CHK(dev_mode, 10'h0aa)
		bus(32'hc, 1'b0, 32'h0, s);
		`CHK(s, 32'h0608_0706)
	endtask : t_mux
	task automatic t_relock;
		wr(32'h0, 32'h4);
		bus(32'h8, 1'b0, 32'h0, s);
		`CHK(s[2], 1'b0)
		for (int i = 0; i < 50 && dev_dll !== 1'b0; i++)
			@(posedge mclk);
		`CHK(dev_dll, 1'b0)
		// Idle again well before the lock count runs out
		poll(32'h1, 32'h0);
		`CHK(s[2], 1'b0)
		poll(32'h5, 32'h4);
		`CHK(dev_dll, 1'b1)
		`CHK(dev_viol, 1'b0)
	endtask : t_relock
	// Reset after a refused start order, then a second init straight into mux mode
	task automatic t_rerun;
		wr(32'h0, 32'h1);
		@(posedge mclk);
		rst_b <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		bus(32'h8, 1'b0, 32'h0, s);
		`CHK(s, 32'h0)
		`CHK(hresp, 1'b0)
		wr(32'h4, 32'h0a2);
		wr(32'h0, 32'h1);
		poll(32'h3, 32'h2);
		`CHK({dev_done, dev_mux, dev_mode}, 12'hca2)
		`CHK(dev_viol, 1'b0)
		bus(32'hc, 1'b0, 32'h0, s);
		`CHK(s, 32'h0608_0706)
	endtask : t_rerun
	////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// Whole run is a few hundred cycles; the ceiling leaves wide margin
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			test_done();
		end
	end
	initial begin
		{rst_b, hsel, hwrite, haddr, hwdata, htrans} = '0;
		hsize = dram_init_pkg::HSIZE_WORD;
		repeat (6) @(posedge mclk);
		rst_b <= 1'b1;
		wr(32'h10, 32'hffff_ffff);
		bus(32'h4, 1'b0, 32'h0, s);
		`CHK(s, 32'h0)
		bus(32'h10, 1'b0, 32'h0, s);
		`CHK(s, 32'h0)
		t_refuse();
		t_init();
		t_mux();
		t_relock();
		t_rerun();
		test_done();
	end
endmodule : dram_init_mode_register_test
`default_nettype wire

// *** verilog/dram_init_ctrl.sv ***
// Host-side power-up and mode-load sequencer for a low-latency DDR DRAM
//
// Function
// - NOPs only for 200 us first
// - Two dummy loads, then valid, back to back
// - Address low during dummy loads
// - Refresh every bank, then 1024 NOPs
// - Row cycle time after refresh per bank
// - Mode load only with all banks idle
// - Settle time after every mode load
// - A10-A17 zero; A18 upward ignored
// - No burst 8 with configs 1 or 4
// - Config 4 write-to-read needs 4 clocks
// - 1024 cycles after DLL enable before reads
// - Clock or supply change: relock DLL
// - Single load with A5 high enters mux mode
// - Settle before the two-cycle mux load
// - Mux load: two parts on consecutive edges
// - A10-A18 low in both mux parts
// - Config 3 only if clock qualifies
//
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module dram_init_ctrl #(
	parameter int POWERUP_CYCLES = dram_init_pkg::POWERUP_CYC,
	parameter int MRSC_CYCLES = dram_init_pkg::MRSC_CYC,
	parameter int NOP_CYCLES = dram_init_pkg::NOP_COUNT,
	parameter int DLL_CYCLES = dram_init_pkg::DLL_LOCK_CYC,
	parameter bit ALLOW_CONFIG3 = 1'b0
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	output var dram_init_pkg::dram_cmd_s dram_cmd
);
	localparam int TW = dram_init_pkg::TIMER_W;
	localparam int BW = dram_init_pkg::BANK_W;
	localparam int MW = dram_init_pkg::MODE_W;
	localparam logic [BW-1:0] DUMMY_LAST = BW'(dram_init_pkg::DUMMY_LOADS - 1);
	localparam logic [BW-1:0] BANK_LAST = BW'(dram_init_pkg::BANKS - 1);

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_POWER,
		ST_DUMMY,
		ST_VALID,
		ST_SETTLE,
		ST_MUX_A,
		ST_MUX_B,
		ST_REFRESH,
		ST_NOPS,
		ST_READY
	} st_e;

	st_e state_q, state_d;
	st_e load_st;
	dram_init_pkg::mode_s mode_q, act_q, act_d, ld_mode;
	dram_init_pkg::dram_cmd_s cmd_d;
	dram_init_pkg::status_s status;
	dram_init_pkg::timing_s timing;
	logic [BW-1:0] cnt_q, cnt_d;
	logic mux_q, mux_d, init_q, init_d, done_q, done_d;
	logic need2_q, need2_d, dll_low_q, dll_low_d, dll_on_q, dll_on_d;
	logic err_q;
	logic ap_ok, ap_wr_q;
	logic [31:0] ap_adr_q, hrdata_q, rd_word;
	logic wr_ctrl, wr_mode;
	logic ord_start, ord_apply, ord_relock, ord_clr;
	logic mode_legal, take_start, take_apply, take_relock, bad_order;
	logic busy, seq_load, seq_exp, dll_load, dll_exp;
	logic [TW-1:0] seq_val;
	logic [3:0] rc, rl;

	////////////////////////////////////////////////////////////////////////
	// Bus slave: zero wait states, always OKAY
	assign ap_ok = hsel && hready && (htrans == dram_init_pkg::HTRANS_NONSEQ)
		&& (hsize == dram_init_pkg::HSIZE_WORD);
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;
	assign wr_ctrl = ap_wr_q && (ap_adr_q == dram_init_pkg::CTRL_OFS);
	assign wr_mode = ap_wr_q && (ap_adr_q == dram_init_pkg::MODE_OFS);
	assign rd_word = (haddr == dram_init_pkg::MODE_OFS) ? 32'(mode_q) :
		(haddr == dram_init_pkg::STATUS_OFS) ? 32'(status) :
		(haddr == dram_init_pkg::TIMING_OFS) ? 32'(timing) : 32'h0;

	// Read data sampled at the address phase, so it shows the state then
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ap_wr_q <= 1'b0;
			ap_adr_q <= '0;
			hrdata_q <= '0;
		end else begin
			ap_wr_q <= ap_ok && hwrite;
			if (ap_ok) begin
				ap_adr_q <= haddr;
			end
			if (ap_ok && !hwrite) begin
				hrdata_q <= rd_word;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q <= '0;
		end else if (wr_mode) begin
			mode_q <= dram_init_pkg::mode_s'(hwdata[MW-1:0]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Orders and their acceptance
	assign ord_start = wr_ctrl && hwdata[dram_init_pkg::CTRL_START];
	assign ord_apply = wr_ctrl && hwdata[dram_init_pkg::CTRL_APPLY];
	assign ord_relock = wr_ctrl && hwdata[dram_init_pkg::CTRL_RELOCK];
	assign ord_clr = wr_ctrl && hwdata[dram_init_pkg::CTRL_CLR_ERR];
	assign mode_legal = dram_init_pkg::cfg_legal(mode_q, ALLOW_CONFIG3);
	// The device has no reset pin, so power-up runs once per controller reset
	assign take_start = ord_start && (state_q == ST_IDLE) && mode_legal;
	// Mux mode cannot be left: a load there must keep A5 high
	assign take_apply = ord_apply && !ord_start && (state_q == ST_READY)
		&& mode_legal && (mode_q.address_mux_select || !mux_q);
	assign take_relock = ord_relock && !ord_start && !ord_apply
		&& (state_q == ST_READY);
	assign bad_order = (ord_start || ord_apply || ord_relock)
		&& !(take_start || take_apply || take_relock);

	// Set wins over clear
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			err_q <= 1'b0;
		end else begin
			err_q <= bad_order || (err_q && !ord_clr);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	assign load_st = mux_q ? ST_MUX_A : ST_VALID;
	assign busy = (state_q != ST_IDLE) && (state_q != ST_READY);

	always_comb begin
		ld_mode = act_q;
		ld_mode.dll_en = act_q.dll_en && !dll_low_q;
	end

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		act_d = act_q;
		mux_d = mux_q;
		init_d = init_q;
		done_d = done_q;
		need2_d = need2_q;
		dll_low_d = dll_low_q;
		dll_on_d = dll_on_q;
		seq_load = 1'b0;
		seq_val = '0;
		dll_load = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (take_start) begin
					state_d = ST_POWER;
					act_d = mode_q;
					init_d = 1'b1;
					seq_load = 1'b1;
					seq_val = TW'(POWERUP_CYCLES - 1);
				end
			end
			ST_POWER: begin
				if (seq_exp) begin
					state_d = ST_DUMMY;
					cnt_d = '0;
				end
			end
			ST_DUMMY: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == DUMMY_LAST) begin
					state_d = ST_VALID;
				end
			end
			ST_VALID, ST_MUX_B: begin
				state_d = ST_SETTLE;
				seq_load = 1'b1;
				seq_val = TW'(MRSC_CYCLES - 1);
				dll_on_d = ld_mode.dll_en;
				dll_load = ld_mode.dll_en;
				if (state_q == ST_MUX_B) begin
					need2_d = 1'b0;
				end else if (ld_mode.address_mux_select && !mux_q) begin
					mux_d = 1'b1;
					need2_d = 1'b1;
				end
			end
			ST_MUX_A: begin
				state_d = ST_MUX_B;
			end
			ST_SETTLE: begin
				if (seq_exp) begin
					if (need2_q) begin
						state_d = ST_MUX_A;
					end else if (dll_low_q) begin
						dll_low_d = 1'b0;
						state_d = load_st;
					end else if (init_q) begin
						state_d = ST_REFRESH;
						cnt_d = '0;
					end else begin
						state_d = ST_READY;
					end
				end
			end
			ST_REFRESH: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == BANK_LAST) begin
					state_d = ST_NOPS;
					seq_load = 1'b1;
					seq_val = TW'(NOP_CYCLES - 1);
				end
			end
			ST_NOPS: begin
				if (seq_exp) begin
					state_d = ST_READY;
					init_d = 1'b0;
					done_d = 1'b1;
				end
			end
			ST_READY: begin
				if (take_apply) begin
					act_d = mode_q;
					state_d = load_st;
				end else if (take_relock) begin
					dll_low_d = 1'b1;
					state_d = load_st;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
			act_q <= '0;
			{mux_q, init_q, done_q} <= 3'h0;
			{need2_q, dll_low_q, dll_on_q} <= 3'h0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			act_q <= act_d;
			{mux_q, init_q, done_q} <= {mux_d, init_d, done_d};
			{need2_q, dll_low_q, dll_on_q} <= {need2_d, dll_low_d, dll_on_d};
		end
	end

	wait_timer #(.W(TW)) u_seq_timer (
		.mclk(mclk),
		.rst_b(rst_b),
		.load(seq_load),
		.value(seq_val),
		.expired(seq_exp)
	);

	// Counts from the pin edge of the enabling load, one cycle of margin
	wait_timer #(.W(TW)) u_dll_timer (
		.mclk(mclk),
		.rst_b(rst_b),
		.load(dll_load),
		.value(TW'(DLL_CYCLES)),
		.expired(dll_exp)
	);

	////////////////////////////////////////////////////////////////////////
	// Pin drive, registered one cycle behind the state
	always_comb begin
		cmd_d.ctl = dram_init_pkg::CMD_NOP;
		cmd_d.bank = '0;
		cmd_d.addr = '0;
		case (state_q)
			ST_DUMMY: begin
				cmd_d.ctl = dram_init_pkg::CMD_MODE_LOAD;
			end
			ST_VALID: begin
				cmd_d.ctl = dram_init_pkg::CMD_MODE_LOAD;
				cmd_d.addr = dram_init_pkg::load_word_single(ld_mode);
			end
			ST_MUX_A: begin
				cmd_d.ctl = dram_init_pkg::CMD_MODE_LOAD;
				cmd_d.addr = dram_init_pkg::load_word_first(ld_mode);
			end
			ST_MUX_B: begin
				cmd_d.addr = dram_init_pkg::load_word_second(ld_mode);
			end
			ST_REFRESH: begin
				cmd_d.ctl = dram_init_pkg::CMD_REFRESH;
				cmd_d.bank = cnt_q;
			end
			default: begin
				cmd_d.ctl = dram_init_pkg::CMD_NOP;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			dram_cmd <= '{ctl: dram_init_pkg::CMD_NOP, bank: '0, addr: '0};
		end else begin
			dram_cmd <= cmd_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status and derived timing
	assign rc = dram_init_pkg::cfg_rc(act_q.cfg);
	assign rl = rc + {3'h0, mux_q};
	assign status.pad = '0;
	assign status.dll_on = dll_on_q;
	assign status.err = err_q;
	assign status.mux_active = mux_q;
	assign status.read_ok = done_q && !busy && dll_on_q && dll_exp;
	assign status.init_done = done_q;
	assign status.busy = busy;
	assign timing.pad3 = '0;
	assign timing.pad2 = '0;
	assign timing.pad1 = '0;
	assign timing.pad0 = '0;
	assign timing.rc = rc;
	assign timing.rl = rl;
	assign timing.wl = rl + 4'h1;
	assign timing.rc_wr_rd = (act_q.cfg == dram_init_pkg::CFG_4) ?
		dram_init_pkg::RC_WR_RD_CFG4 : rc;
endmodule : dram_init_ctrl
`default_nettype wire

// *** verilog/dram_init_pkg.sv ***
// Constants, types and helpers shared by the DRAM init controller
`default_nettype none
package dram_init_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock and sequence timing
	localparam int CLK_MHZ = 50;
	localparam int POWERUP_US = 200;
	localparam int POWERUP_CYC = POWERUP_US * CLK_MHZ;
	// Settle time after a mode load; no figure known, plain default
	localparam int MRSC_CYC = 4;
	localparam int NOP_COUNT = 1024;
	localparam int DLL_LOCK_CYC = 1024;
	localparam int BANKS = 8;
	localparam int DUMMY_LOADS = 2;
	localparam int TIMER_W = 16;

	////////////////////////////////////////////////////////////////////////
	// Pin widths and command codes, ordered {sel_b, we_b, ref_b}
	localparam int ADDR_W = 22;
	localparam int BANK_W = 3;
	localparam int MODE_W = 10;
	localparam logic [2:0] CMD_NOP = 3'h7;
	localparam logic [2:0] CMD_MODE_LOAD = 3'h0;
	localparam logic [2:0] CMD_REFRESH = 3'h2;

	////////////////////////////////////////////////////////////////////////
	// Register map and control bits
	localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
	localparam logic [31:0] MODE_OFS = 32'h0000_0004;
	localparam logic [31:0] STATUS_OFS = 32'h0000_0008;
	localparam logic [31:0] TIMING_OFS = 32'h0000_000c;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam int CTRL_START = 0;
	localparam int CTRL_APPLY = 1;
	localparam int CTRL_RELOCK = 2;
	localparam int CTRL_CLR_ERR = 3;

	////////////////////////////////////////////////////////////////////////
	// Mode field codes and cycle figures
	localparam logic [1:0] BURST_2 = 2'h0;
	localparam logic [1:0] BURST_4 = 2'h1;
	localparam logic [1:0] BURST_8 = 2'h2;
	localparam logic [1:0] BURST_RSV = 2'h3;
	localparam logic [2:0] CFG_1A = 3'h0;
	localparam logic [2:0] CFG_1B = 3'h1;
	localparam logic [2:0] CFG_2 = 3'h2;
	localparam logic [2:0] CFG_3 = 3'h3;
	localparam logic [2:0] CFG_4 = 3'h4;
	localparam logic [2:0] CFG_5 = 3'h5;
	localparam logic [2:0] CFG_R6 = 3'h6;
	localparam logic [2:0] CFG_R7 = 3'h7;
	localparam logic [3:0] RC_CFG1 = 4'h4;
	localparam logic [3:0] RC_CFG2 = 4'h6;
	localparam logic [3:0] RC_CFG3 = 4'h8;
	localparam logic [3:0] RC_CFG4 = 4'h3;
	localparam logic [3:0] RC_CFG5 = 4'h5;
	localparam logic [3:0] RC_WR_RD_CFG4 = 4'h4;

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef struct packed {
		logic termination_enable;
		logic impedance_select;
		logic dll_en;
		logic spare;
		logic address_mux_select;
		logic [1:0] burst_length_field;
		logic [2:0] cfg;
	} mode_s;

	typedef struct packed {
		logic [2:0] ctl;
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] addr;
	} dram_cmd_s;

	typedef struct packed {
		logic [25:0] pad;
		logic dll_on;
		logic err;
		logic mux_active;
		logic read_ok;
		logic init_done;
		logic busy;
	} status_s;

	typedef struct packed {
		logic [3:0] pad3;
		logic [3:0] rc_wr_rd;
		logic [3:0] pad2;
		logic [3:0] wl;
		logic [3:0] pad1;
		logic [3:0] rl;
		logic [3:0] pad0;
		logic [3:0] rc;
	} timing_s;

	////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [3:0] cfg_rc(input logic [2:0] c);
		case (c)
			CFG_1A, CFG_1B: return RC_CFG1;
			CFG_2: return RC_CFG2;
			CFG_3: return RC_CFG3;
			CFG_4: return RC_CFG4;
			CFG_5: return RC_CFG5;
			default: return 4'h0;
		endcase
	endfunction : cfg_rc

	function automatic logic cfg_legal(input mode_s m, input logic allow3);
		logic slow;
		slow = (m.cfg == CFG_1A) || (m.cfg == CFG_1B) || (m.cfg == CFG_4);
		return (m.cfg != CFG_R6) && (m.cfg != CFG_R7) &&
			(m.burst_length_field != BURST_RSV) &&
			!(slow && (m.burst_length_field == BURST_8)) &&
			(allow3 || (m.cfg != CFG_3));
	endfunction : cfg_legal

	// Upper address bits stay zero in every load word
	function automatic logic [ADDR_W-1:0] load_word_single(input mode_s m);
		mode_s w;
		w = m;
		w.spare = 1'b0;
		return ADDR_W'(w);
	endfunction : load_word_single

	function automatic logic [ADDR_W-1:0] load_word_first(input mode_s m);
		mode_s w;
		w = '0;
		w.termination_enable = m.termination_enable;
		w.impedance_select = m.impedance_select;
		w.address_mux_select = 1'b1;
		w.burst_length_field = m.burst_length_field;
		w.cfg[0] = m.cfg[0];
		return ADDR_W'(w);
	endfunction : load_word_first

	// Second part reuses the A9 and A4:A3 positions
	function automatic logic [ADDR_W-1:0] load_word_second(input mode_s m);
		mode_s w;
		w = '0;
		w.termination_enable = m.dll_en;
		w.burst_length_field = m.cfg[2:1];
		return ADDR_W'(w);
	endfunction : load_word_second

endpackage : dram_init_pkg
`default_nettype wire

// *** verilog/wait_timer.sv ***
// Loadable down-counter used for sequence waits
`timescale 1ns/1ns
`default_nettype none
module wait_timer #(
	parameter int W = 16
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic load,
	input wire logic [W-1:0] value,
	output logic expired
);
	logic [W-1:0] cnt_q;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= '0;
		end else if (load) begin
			cnt_q <= value;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	assign expired = (cnt_q == '0);
endmodule : wait_timer
`default_nettype wire
